// file: lmc_pkg.sv
// shared constants, types and state layout of the logger mission control block
package lmc_pkg;

	// ********************************************************
	// bus geometry and register indices (byte address = 4 * index)
	// ********************************************************
	localparam int           ADDR_W       = 12;
	localparam int           DATA_W       = 32;
	localparam logic [9:0]   IDX_ALM_SEC  = 10'h207;
	localparam logic [9:0]   IDX_ALM_DAY  = 10'h20a;
	localparam logic [9:0]   IDX_LOW_THR  = 10'h20b;
	localparam logic [9:0]   IDX_HIGH_THR = 10'h20c;
	localparam logic [9:0]   IDX_RATE     = 10'h20d;
	localparam logic [9:0]   IDX_CTRL     = 10'h20e;
	localparam logic [9:0]   IDX_READOUT  = 10'h211;
	localparam logic [9:0]   IDX_STATUS   = 10'h214;
	localparam logic [9:0]   IDX_CMD      = 10'h220;
	localparam logic [9:0]   IDX_DEG      = 10'h221;
	localparam logic [9:0]   IDX_PAGE_LO  = 10'h200;
	localparam logic [9:0]   IDX_PAGE_HI  = 10'h213;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int           CTRL_OSC_HALT = 7;
	localparam int           CTRL_WIPE_ARM = 6;
	localparam int           CTRL_BLOCK    = 4;
	localparam int           CTRL_WRAP     = 3;
	localparam int           CTRL_LOW_EN   = 2;
	localparam int           CTRL_HIGH_EN  = 1;
	localparam int           CTRL_TIMER_EN = 0;
	localparam logic [7:0]   CTRL_WMASK    = 8'hdf;
	localparam int           ST_WIPED      = 6;
	localparam int           ST_MISSION    = 5;
	localparam int           ST_TLF        = 2;
	localparam int           ST_THF        = 1;
	localparam int           ST_TAF        = 0;
	localparam int           ALM_MASK_BIT  = 7;

	// ********************************************************
	// reset values and codes
	// ********************************************************
	localparam logic [7:0]   CTRL_RST      = 8'h00;
	localparam logic [7:0]   REG_RST       = 8'h00;
	localparam logic [7:0]   CODE_UNDER    = 8'h00;
	localparam logic [7:0]   CODE_OVER     = 8'hff;
	localparam logic [7:0]   CODE_SPEC_LO  = 8'h04;
	localparam logic [7:0]   CODE_SPEC_HI  = 8'hfb;
	localparam logic [7:0]   CMD_CLEAR_MEM = 8'h01;
	localparam logic [7:0]   SEC_ZERO      = 8'h00;
	localparam logic [7:0]   RATE_ZERO     = 8'h00;
	localparam logic [7:0]   CNT_LAST      = 8'h01;
	localparam logic [9:0]   DEG8_OFS_HIGH = 10'h074;
	localparam logic [9:0]   DEG8_OFS_LOW  = 10'h3d4;

	typedef enum logic {BUS_IDLE, BUS_ACK} lmc_bus_e;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [3:0]        byteenable;
	} lmc_avs_s;

	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] dow;
	} lmc_rtc_s;

	typedef struct packed {
		logic       done;
		logic       under;
		logic       over;
		logic [7:0] code;
	} lmc_conv_s;

	typedef struct packed {
		logic       store;
		logic       hist_inc;
		logic [5:0] bin;
		logic [7:0] code;
	} lmc_log_s;

	typedef struct packed {
		lmc_bus_e          bus;
		logic              wreq;
		logic [DATA_W-1:0] rdata;
		logic [3:0][7:0]   alm;
		logic [7:0]        low_thr;
		logic [7:0]        high_thr;
		logic [7:0]        rate;
		logic [7:0]        ctrl;
		logic [7:0]        readout;
		logic [9:0]        deg8;
		logic              mission;
		logic              wiped;
		logic              timer_alarm_flag;
		logic              tlf;
		logic              thf;
		logic              osc_run;
		logic              osc_ok;
		logic [7:0]        min_cnt;
		logic              alarm;
		logic              sample_req;
		logic              wipe;
		logic              wipe_next;
		logic              search;
		lmc_log_s          log;
	} lmc_state_s;

endpackage

// file: lmc_field_match.sv
// one masked alarm field comparator
`timescale 1ns/1ps
module lmc_field_match #(
	parameter int W = 7
) (
	input  wire logic [W-1:0] cur_i,
	input  wire logic [W-1:0] alm_i,
	input  wire logic         mask_i,
	output logic              hit_o
);
	// a set mask bit makes the field a don't-care
	assign hit_o = mask_i | (cur_i == alm_i);
endmodule

// file: lmc_temp_code.sv
// temperature code mapping: out-of-range clamp, validity, bin and degrees
`timescale 1ns/1ps
module lmc_temp_code
	import lmc_pkg::*;
#(
	parameter bit HIGH_VARIANT = 1'b1
) (
	input  wire lmc_conv_s  conv_i,
	output logic [7:0]      code_o,
	output logic            valid_o,
	output logic            in_spec_o,
	output logic [5:0]      bin_o,
	output logic [9:0]      deg8_o
);
	// degrees in eighths: code + 116 or code - 44
	localparam logic [9:0] OFS = HIGH_VARIANT ? DEG8_OFS_HIGH : DEG8_OFS_LOW;

	always_comb
	begin
		if (conv_i.under)
			code_o = CODE_UNDER;
		else if (conv_i.over)
			code_o = CODE_OVER;
		else
			code_o = conv_i.code;
		valid_o   = (code_o != CODE_UNDER) && (code_o != CODE_OVER);
		in_spec_o = (code_o >= CODE_SPEC_LO) && (code_o <= CODE_SPEC_HI);
		// 00h-03h fall in bin 0, fch-ffh in bin 63
		bin_o     = code_o[7:2];
		deg8_o    = {2'b00, code_o} + OFS;
	end
endmodule

// file: lmc_top.sv
// logger mission control: register page, alarm decode, mission start/stop, logging control
// Contract
// [RL1] all four alarm masks set: alarm every second.
// [RL2] only seconds mask clear: alarm on seconds match, once a minute.
// [RL3] seconds and minutes masks clear: alarm hourly on minutes and seconds match.
// [RL4] only day mask set: daily alarm; all clear: weekly alarm incl. day.
// [RL5] temperature is one unsigned byte, eighth-degree steps, 32 degree span.
// [RL6] under range records 00h, over range ffh; 01h-feh are valid.
// [RL7] codes 04h-fbh are specified, bins 1-62; out-of-range in bins 0, 63.
// [RL8] same code-to-degree mapping for log and readout: code/8 +14.5 or -5.5.
// [RL9] host encodes thresholds as 8*deg-116 or 8*deg+44.
// [RL10] conversions spaced by sample-rate minutes, 1 to 255.
// [RL11] wiped flag set, block clear: non-zero rate write starts a mission.
// [RL12] control write during a mission ends it and updates the register.
// [RL13] control bit 5 reads zero and cannot be set.
// [RL14] oscillator runs while halt bit is zero, stops when one.
// [RL15] mission start refused until rtc advanced one second after oscillator enable.
// [RL16] armed wipe clears memory, counters and rate only on next clear command.
// [RL17] wipe arm bit drops on the next memory function command.
// [RL18] rate write starts a mission only with mission block bit zero.
// [RL19] wrap bit set: logging restarts at beginning when memory fills.
// [RL20] wrap bit clear: storing stops when full, mission keeps running.
// [RL21] low/high search enables answer search on threshold crossings.
// [RL22] timer search enable answers search after a timer alarm.
// [RL23] every alarm match sets the timer alarm flag.
// [RL24] first write to 200h-213h ends a running mission.
// [RL25] alarm compared once per seconds update, at most one event per second.
`timescale 1ns/1ps
module lmc_top
	import lmc_pkg::*;
#(
	parameter bit HIGH_VARIANT = 1'b1
) (
	input  wire logic                   ref_clk_i,
	input  wire logic                   sys_rst_i,
	input  wire lmc_pkg::lmc_avs_s      avs_i,
	output logic [lmc_pkg::DATA_W-1:0]  avs_readdata_o,
	output logic                        avs_waitrequest_o,
	input  wire logic                   rtc_tick_i,
	input  wire lmc_pkg::lmc_rtc_s      rtc_i,
	input  wire lmc_pkg::lmc_conv_s     conv_i,
	input  wire logic                   log_full_i,
	output logic                        osc_run_o,
	output logic                        mission_active_o,
	output logic                        alarm_o,
	output logic                        sample_req_o,
	output logic                        wipe_o,
	output logic                        wrap_log_o,
	output logic                        search_match_o,
	output lmc_pkg::lmc_log_s           log_o
);
	import lmc_pkg::*;

	lmc_state_s st_r;
	lmc_state_s st_nxt;

	// ********************************************************
	// alarm field comparators
	// ********************************************************
	logic [3:0] fld_hit;
	logic [3:0][6:0] fld_cur;

	assign fld_cur[0] = rtc_i.sec[6:0];
	assign fld_cur[1] = rtc_i.min[6:0];
	assign fld_cur[2] = rtc_i.hour[6:0];
	assign fld_cur[3] = rtc_i.dow[6:0];

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_fld
			lmc_field_match #(
				.W (7)
			) u_fld (
				.cur_i  (fld_cur[g]),
				.alm_i  (st_r.alm[g][6:0]),
				.mask_i (st_r.alm[g][ALM_MASK_BIT]),
				.hit_o  (fld_hit[g])
			);
		end
	endgenerate

	// ********************************************************
	// conversion result mapping
	// ********************************************************
	logic [7:0] t_code;
	logic       t_valid;
	logic       t_in_spec;
	logic [5:0] t_bin;
	logic [9:0] t_deg8;

	lmc_temp_code #(
		.HIGH_VARIANT (HIGH_VARIANT)
	) u_tcode (
		.conv_i    (conv_i),
		.code_o    (t_code),
		.valid_o   (t_valid),
		.in_spec_o (t_in_spec),
		.bin_o     (t_bin),
		.deg8_o    (t_deg8)
	);

	// ********************************************************
	// next-state logic
	// ********************************************************
	logic [9:0] idx;
	logic       req;
	logic       wr_go;
	logic       in_page;
	logic [7:0] wd;
	logic       alarm_hit;
	logic       minute_edge;
	logic       tlf_set;
	logic       thf_set;

	assign idx     = avs_i.address[ADDR_W-1:2];
	assign req     = avs_i.read | avs_i.write;
	assign wd      = avs_i.writedata[7:0];
	assign in_page = (idx >= IDX_PAGE_LO) && (idx <= IDX_PAGE_HI);
	// the write takes effect on the edge where the master sees waitrequest low
	assign wr_go   = (st_r.bus == BUS_ACK) && avs_i.write && avs_i.byteenable[0];

	// one comparison per seconds update only
	assign alarm_hit   = rtc_tick_i && (&fld_hit); // [RL25] [RL1] [RL2] [RL3] [RL4]
	assign minute_edge = rtc_tick_i && (rtc_i.sec == SEC_ZERO);
	// a threshold flag is raised by any mission reading past its threshold, under and over range codes included
	assign tlf_set = conv_i.done && st_r.mission && (t_code <= st_r.low_thr); // [RL21]
	assign thf_set = conv_i.done && st_r.mission && (t_code >= st_r.high_thr); // [RL21]

	// ********************************************************
	// wipe sequencing and mission start qualification
	// ********************************************************
	logic acc_go;
	logic start_ok;

	// any completed access, read or write, ends the window in which a clear may fire
	assign acc_go   = (st_r.bus == BUS_ACK) && req;
	// mission start needs a wiped log, no block and an rtc that has ticked since enable
	assign start_ok = !st_r.mission && st_r.wiped && st_r.osc_ok && !st_r.ctrl[CTRL_BLOCK]; // [RL11] [RL18] [RL15]

	always_comb
	begin
		st_nxt            = st_r;
		st_nxt.alarm      = 1'b0;
		st_nxt.sample_req = 1'b0;
		st_nxt.wipe       = 1'b0;
		st_nxt.log.store  = 1'b0;
		st_nxt.log.hist_inc = 1'b0;

		// bus handshake: one wait cycle, then a single acknowledge cycle
		case (st_r.bus)
			BUS_IDLE:
			begin
				if (req)
				begin
					st_nxt.bus  = BUS_ACK;
					st_nxt.wreq = 1'b0;
				end
			end
			BUS_ACK:
			begin
				st_nxt.bus  = BUS_IDLE;
				st_nxt.wreq = 1'b1;
			end
			default:
			begin
				st_nxt.bus  = BUS_IDLE;
				st_nxt.wreq = 1'b1;
			end
		endcase

		// read data latched one cycle ahead so it stands at the acknowledge edge
		st_nxt.rdata = '0;
		if ((st_r.bus == BUS_IDLE) && avs_i.read)
		begin
			if ((idx >= IDX_ALM_SEC) && (idx <= IDX_ALM_DAY))
				st_nxt.rdata[7:0] = st_r.alm[idx[1:0] - IDX_ALM_SEC[1:0]];
			else
			begin
				case (idx)
					IDX_LOW_THR:  st_nxt.rdata[7:0] = st_r.low_thr;
					IDX_HIGH_THR: st_nxt.rdata[7:0] = st_r.high_thr;
					IDX_RATE:     st_nxt.rdata[7:0] = st_r.rate;
					IDX_CTRL:     st_nxt.rdata[7:0] = st_r.ctrl & CTRL_WMASK; // [RL13]
					IDX_READOUT:  st_nxt.rdata[7:0] = st_r.readout;
					IDX_DEG:      st_nxt.rdata[9:0] = st_r.deg8; // [RL8]
					IDX_STATUS:
					begin
						st_nxt.rdata[ST_WIPED]   = st_r.wiped;
						st_nxt.rdata[ST_MISSION] = st_r.mission;
						st_nxt.rdata[ST_TLF]     = st_r.tlf;
						st_nxt.rdata[ST_THF]     = st_r.thf;
						st_nxt.rdata[ST_TAF]     = st_r.timer_alarm_flag;
					end
					default:      st_nxt.rdata = '0;
				endcase
			end
		end

		// rtc oscillator supervision
		st_nxt.osc_run = ~st_r.ctrl[CTRL_OSC_HALT]; // [RL14]
		if (st_r.ctrl[CTRL_OSC_HALT])
			st_nxt.osc_ok = 1'b0; // [RL15]
		else if (rtc_tick_i)
			st_nxt.osc_ok = 1'b1; // [RL15]

		// register writes
		if (wr_go)
		begin
			// any write in the page stops a running mission
			if (in_page && st_r.mission)
				st_nxt.mission = 1'b0; // [RL24] [RL12]
			if ((idx >= IDX_ALM_SEC) && (idx <= IDX_ALM_DAY))
				st_nxt.alm[idx[1:0] - IDX_ALM_SEC[1:0]] = wd;
			case (idx)
				IDX_LOW_THR:  st_nxt.low_thr  = wd;
				IDX_HIGH_THR: st_nxt.high_thr = wd;
				IDX_CTRL:     st_nxt.ctrl     = wd & CTRL_WMASK; // [RL13] [RL12]
				IDX_RATE:
				begin
					st_nxt.rate = wd; // [RL10]
					if (start_ok && (wd != RATE_ZERO)) // [RL11] [RL18] [RL15]
					begin
						st_nxt.mission = 1'b1;
						st_nxt.wiped   = 1'b0;
						st_nxt.min_cnt = wd;
					end
				end
				IDX_STATUS:
				begin
					// status bits other than wiped clear on a written zero, a one is ignored
					if (!wd[ST_MISSION])
						st_nxt.mission = 1'b0;
					if (!wd[ST_TLF])
						st_nxt.tlf = 1'b0;
					if (!wd[ST_THF])
						st_nxt.thf = 1'b0;
					if (!wd[ST_TAF])
						st_nxt.timer_alarm_flag = 1'b0;
				end
				IDX_CMD:
				begin
					// every memory function command disarms the wipe
					st_nxt.ctrl[CTRL_WIPE_ARM] = 1'b0; // [RL17]
					if (st_r.ctrl[CTRL_WIPE_ARM] && st_r.wipe_next
						&& (wd == CMD_CLEAR_MEM)) // [RL16]
					begin
						st_nxt.wipe    = 1'b1;
						st_nxt.rate    = RATE_ZERO;
						st_nxt.wiped   = 1'b1;
						st_nxt.mission = 1'b0;
					end
				end
				default:
				begin
				end
			endcase
		end

		// the arming write opens the window, any later access closes it again
		if (acc_go)
			st_nxt.wipe_next = 1'b0;
		if (wr_go && (idx == IDX_CTRL) && wd[CTRL_WIPE_ARM])
		begin
			// the arm bit stays readable; a clear fires only with the arm bit set and the window still open
			st_nxt.wipe_next = 1'b1; // [RL16]
		end

		// alarm events; placed after writes so a set beats a same-cycle clear
		if (alarm_hit)
		begin
			st_nxt.alarm = 1'b1;
			st_nxt.timer_alarm_flag   = 1'b1; // [RL23]
		end
		if (tlf_set)
			st_nxt.tlf = 1'b1;
		if (thf_set)
			st_nxt.thf = 1'b1;

		// sample interval countdown, in whole minutes
		if (st_r.mission && minute_edge)
		begin
			if (st_r.min_cnt <= CNT_LAST) // [RL10]
			begin
				st_nxt.sample_req = 1'b1;
				st_nxt.min_cnt    = st_r.rate;
			end
			else
				st_nxt.min_cnt = st_r.min_cnt - CNT_LAST;
		end

		// conversion results: readout always, logging only during a mission
		if (conv_i.done)
		begin
			st_nxt.readout = t_code; // [RL6] [RL5]
			st_nxt.deg8    = t_deg8; // [RL8]
			if (st_r.mission)
			begin
				st_nxt.log.code     = t_code; // [RL6]
				st_nxt.log.bin      = t_bin; // [RL7]
				st_nxt.log.hist_inc = 1'b1; // [RL20]
				// with wrap off a full log just stops storing
				st_nxt.log.store    = !log_full_i || st_r.ctrl[CTRL_WRAP]; // [RL19] [RL20]
			end
		end

		st_nxt.search = (st_r.ctrl[CTRL_LOW_EN] && st_r.tlf) // [RL21]
			|| (st_r.ctrl[CTRL_HIGH_EN] && st_r.thf) // [RL21]
			|| (st_r.ctrl[CTRL_TIMER_EN] && st_r.timer_alarm_flag); // [RL22]
	end

	// ********************************************************
	// state register
	// ********************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			st_r          <= '0;
			st_r.bus      <= BUS_IDLE;
			st_r.wreq     <= 1'b1;
			st_r.ctrl     <= CTRL_RST;
			st_r.low_thr  <= REG_RST;
			st_r.high_thr <= REG_RST;
			st_r.rate     <= RATE_ZERO;
			st_r.osc_run  <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// ********************************************************
	// outputs, all straight from state flops
	// ********************************************************
	assign avs_readdata_o    = st_r.rdata;
	assign avs_waitrequest_o = st_r.wreq;
	assign osc_run_o         = st_r.osc_run;
	assign mission_active_o  = st_r.mission;
	assign alarm_o           = st_r.alarm;
	assign sample_req_o      = st_r.sample_req;
	assign wipe_o            = st_r.wipe;
	assign wrap_log_o        = st_r.ctrl[CTRL_WRAP]; // [RL19]
	assign search_match_o    = st_r.search;
	assign log_o             = st_r.log;

endmodule

// file: lmc_chk.sv
// assertion checker watching the logger mission control ports
`timescale 1ns/1ps
module lmc_chk
(
	input	wire logic			ref_clk_i,
	input	wire logic			sys_rst_i,
	input	wire lmc_pkg::lmc_avs_s		avs_i,
	input	wire logic			avs_waitrequest_o,
	input	wire logic			rtc_tick_i,
	input	wire lmc_pkg::lmc_rtc_s		rtc_i,
	input	wire lmc_pkg::lmc_conv_s	conv_i,
	input	wire logic			log_full_i,
	input	wire logic			osc_run_o,
	input	wire logic			mission_active_o,
	input	wire logic			alarm_o,
	input	wire logic			sample_req_o,
	input	wire logic			wrap_log_o,
	input	wire lmc_pkg::lmc_log_s		log_o
);
	import lmc_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// ********
	// shadow of the four alarm mask bits
	// ********
	logic	[3:0]	msk_r;
	logic	[3:0]	msk_nxt;
	logic		ack;
	logic	[9:0]	idx;
	assign idx = avs_i.address[11:2];
	assign ack = avs_i.write && !avs_waitrequest_o && avs_i.byteenable[0];
	always_comb
	begin
		msk_nxt = msk_r;
		if (ack && idx >= IDX_ALM_SEC && idx <= IDX_ALM_DAY)
			msk_nxt[2'(idx - IDX_ALM_SEC)] = avs_i.writedata[ALM_MASK_BIT];
	end
	always_ff @(posedge ref_clk_i)
		msk_r <= sys_rst_i ? 4'h0 : msk_nxt;
	// ********
	// sequences and assertions
	// ********
	logic		store_ok;
	logic		min_ok;
	assign store_ok = conv_i.done && mission_active_o && (!log_full_i || wrap_log_o);
	assign min_ok = rtc_tick_i && rtc_i.sec == SEC_ZERO && mission_active_o;
	sequence s_conv;
		conv_i.done && mission_active_o;
	endsequence
	sequence s_under;
		s_conv ##0 conv_i.under;
	endsequence
	sequence s_over;
		s_conv ##0 conv_i.over && !conv_i.under;
	endsequence
	sequence s_in_range;
		s_conv ##0 !conv_i.under && !conv_i.over;
	endsequence
	sequence s_page_wr;
		ack && idx >= IDX_PAGE_LO && idx <= IDX_PAGE_HI && mission_active_o;
	endsequence
	sequence s_ctrl_wr;
		ack && idx == IDX_CTRL;
	endsequence
	alarm_tick_a: assert property (alarm_o |-> $past(rtc_tick_i))
		else $error("alarm without seconds update");
	alarm_all_a: assert property (rtc_tick_i && msk_r == 4'hf |=> alarm_o)
		else $error("per-second alarm missed");
	store_gate_a: assert property (log_o.store |-> $past(store_ok))
		else $error("log store not allowed");
	hist_inc_a: assert property (s_conv |=> log_o.hist_inc)
		else $error("histogram not bumped");
	under_code_a: assert property (s_under |=> log_o.code == CODE_UNDER && log_o.bin == 6'h00)
		else $error("under range code wrong");
	over_code_a: assert property (s_over |=> log_o.code == CODE_OVER && log_o.bin == 6'h3f)
		else $error("over range code wrong");
	code_pass_a: assert property (s_in_range |=> log_o.code == $past(conv_i.code))
		else $error("valid code altered");
	bin_map_a: assert property (s_in_range |=> log_o.bin == $past(conv_i.code[7:2]))
		else $error("bin wrong");
	osc_follow_a: assert property (s_ctrl_wr |-> ##2 osc_run_o == !$past(avs_i.writedata[CTRL_OSC_HALT], 2))
		else $error("oscillator run wrong");
	page_end_a: assert property (s_page_wr |=> !mission_active_o)
		else $error("mission not ended");
	sample_min_a: assert property (sample_req_o |-> $past(min_ok))
		else $error("sample off minute");
endmodule

bind lmc_top lmc_chk lmc_chk_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .avs_i(avs_i),
	.avs_waitrequest_o(avs_waitrequest_o), .rtc_tick_i(rtc_tick_i), .rtc_i(rtc_i), .conv_i(conv_i),
	.log_full_i(log_full_i), .osc_run_o(osc_run_o), .mission_active_o(mission_active_o), .alarm_o(alarm_o),
	.sample_req_o(sample_req_o), .wrap_log_o(wrap_log_o), .log_o(log_o));

// file: lmc_far_model.sv
// behavioural rtc and temperature core model
`timescale 1ns/1ps
module lmc_far_model
(
	input	wire logic			ref_clk_i,
	input	wire logic			sample_req_i,
	input	wire lmc_pkg::lmc_conv_s	next_i,
	output	logic				rtc_tick_o,
	output	lmc_pkg::lmc_rtc_s		rtc_o,
	output	lmc_pkg::lmc_conv_s		conv_o
);
	import lmc_pkg::*;
	int	sec = 0;
	int	mnt = 0;
	int	lag = 0;
	function automatic logic [7:0] bcd(input int v);
		return {4'(v / 10), 4'(v % 10)};
	endfunction
	initial
	begin
		rtc_tick_o = 1'b0;
		rtc_o = '0;
		conv_o = '0;
	end
	task automatic set_time(input int s, input int m, input int h, input int d);
		@(posedge ref_clk_i);
		sec = s;
		mnt = m;
		rtc_o <= {bcd(s), bcd(m), bcd(h), bcd(d)};
	endtask
	// time is updated together with the tick pulse
	task automatic tick();
		@(posedge ref_clk_i);
		sec = (sec + 1) % 60;
		if (sec == 0)
			mnt = (mnt + 1) % 60;
		rtc_o.sec <= bcd(sec);
		rtc_o.min <= bcd(mnt);
		rtc_tick_o <= 1'b1;
		@(posedge ref_clk_i);
		rtc_tick_o <= 1'b0;
	endtask
	// result a few cycles after the request; the code is inverted once, the cycle after done, so stale data no longer matches the result
	always @(posedge ref_clk_i)
	begin
		conv_o.done <= 1'b0;
		if (sample_req_i)
			lag <= 3;
		else if (lag > 0)
			lag <= lag - 1;
		if (lag == 1)
			conv_o <= {1'b1, next_i.under, next_i.over, next_i.code};
		else if (conv_o.done)
			conv_o.code <= ~conv_o.code;
	end
endmodule

// file: lmc_bench.sv
// self-checking bench for the logger mission control block
`timescale 1ns/1ps
module lmc_bench;
	import lmc_pkg::*;
	logic			clk = 1'b0;
	logic			rst = 1'b1;
	lmc_avs_s		avs = '0;
	lmc_conv_s		next = '0;
	logic			full = 1'b0;
	logic	[DATA_W-1:0]	rdata;
	logic	[DATA_W-1:0]	rd;
	logic			wreq, tick, osc_run, mis, alarm, samp, wipe, wrap, srch;
	lmc_rtc_s		rtc;
	lmc_conv_s		conv;
	lmc_log_s		lg;
	int			err_total = 0;
	int			samples_checked = 0;
	int			n_alarm = 0, n_wipe = 0, n_samp = 0, n_store = 0, n_hist = 0, k;
	logic	[9:0]		regs[4] = '{IDX_LOW_THR, IDX_HIGH_THR, IDX_RATE, IDX_CTRL};
	logic	[10:0]		cv[5] = '{11'h050, 11'h004, 11'h0fb, 11'h237, 11'h112};
	logic	[7:0]		cx[5] = '{8'h50, 8'h04, 8'hfb, 8'h00, 8'hff};
	logic	[7:0]		al[9][5] = '{'{8'hb3, 8'h91, 8'h91, 8'h81, 1}, '{0, 8'h80, 8'h80, 8'h80, 1},
		'{1, 8'h80, 8'h80, 8'h80, 0}, '{0, 6, 8'h80, 8'h80, 1}, '{0, 7, 8'h80, 8'h80, 0},
		'{0, 6, 4, 8'h80, 0}, '{0, 6, 3, 8'h80, 1}, '{0, 6, 3, 2, 1}, '{0, 6, 3, 5, 0}};
	always #10 clk = ~clk;
	lmc_top lmc_top_i (.ref_clk_i(clk), .sys_rst_i(rst), .avs_i(avs), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .rtc_tick_i(tick), .rtc_i(rtc), .conv_i(conv), .log_full_i(full),
		.osc_run_o(osc_run), .mission_active_o(mis), .alarm_o(alarm), .sample_req_o(samp), .wipe_o(wipe),
		.wrap_log_o(wrap), .search_match_o(srch), .log_o(lg));
	lmc_far_model lmc_far_model_i (.ref_clk_i(clk), .sample_req_i(samp), .next_i(next), .rtc_tick_o(tick),
		.rtc_o(rtc), .conv_o(conv));
	always @(posedge clk)
	begin
		n_alarm <= n_alarm + int'(alarm);
		n_wipe <= n_wipe + int'(wipe);
		n_samp <= n_samp + int'(samp);
		n_store <= n_store + int'(lg.store);
		n_hist <= n_hist + int'(lg.hist_inc);
	end
	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// request held until the edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs <= {!wr, wr, idx, 2'b00, 24'h0, d, 4'hf};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wreq !== 1'b0 && n < 50);
		if (n >= 50)
		begin
			err_total++;
			test_done();
		end
		rd = rdata;
		avs.read <= 1'b0;
		avs.write <= 1'b0;
	endtask
	task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
		bus(0, idx, 8'h00);
		chk(rd, {24'h0, exp});
	endtask
	task automatic chkm(input logic exp);
		@(posedge clk);
		chk(32'(mis), 32'(exp));
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rdc(regs[i], 8'h00);
			bus(1, regs[i], 8'ha5);
			rdc(regs[i], regs[i] == IDX_CTRL ? 8'h85 : 8'ha5);
		end
		chk(32'(osc_run), 0);
		chk(32'(wrap), 0);
		bus(1, 10'h3ff, 8'hff);
		rdc(10'h3ff, 8'h00);
		bus(1, IDX_LOW_THR, 8'h44);
		bus(1, IDX_HIGH_THR, 8'h7c);
		// timer search kept off while logging
		bus(1, IDX_CTRL, 8'h46);
		repeat (2) @(posedge clk);
		chk(32'(osc_run), 1);
		bus(1, IDX_CMD, 8'h02);
		rdc(IDX_CTRL, 8'h06);
		chk(n_wipe, 0);
		// a read between arming and the clear command spoils the wipe
		bus(1, IDX_CTRL, 8'h46);
		rdc(IDX_CTRL, 8'h46);
		bus(1, IDX_CMD, CMD_CLEAR_MEM);
		rdc(IDX_CTRL, 8'h06);
		chk(n_wipe, 0);
		bus(1, IDX_CTRL, 8'h46);
		bus(1, IDX_CMD, CMD_CLEAR_MEM);
		repeat (2) @(posedge clk);
		chk(n_wipe, 1);
		rdc(IDX_RATE, 8'h00);
		rdc(IDX_CTRL, 8'h06);
		bus(1, IDX_RATE, 8'h02);
		chkm(0);
		lmc_far_model_i.set_time(59, 59, 3, 2);
		lmc_far_model_i.tick();
		bus(1, IDX_CTRL, 8'h16);
		bus(1, IDX_RATE, 8'h02);
		chkm(0);
		bus(1, IDX_CTRL, 8'h06);
		bus(1, IDX_RATE, 8'h00);
		chkm(0);
		bus(1, IDX_RATE, 8'h02);
		chkm(1);
		bus(0, IDX_STATUS, 8'h00);
		chk(32'(rd[ST_WIPED]), 0);
		for (int i = 0; i < 5; i++)
		begin
			next <= cv[i];
			full <= (i < 4);
			repeat (60) lmc_far_model_i.tick();
			if (i == 0)
				chk(n_samp, 0);
			repeat (60) lmc_far_model_i.tick();
			repeat (6) @(posedge clk);
			chk(n_samp, i + 1);
			chk(32'(lg.code), 32'(cx[i]));
			chk(32'(lg.bin), 32'(cx[i][7:2]));
			rdc(IDX_READOUT, cx[i]);
			bus(0, IDX_DEG, 8'h00);
			chk(rd, 32'(10'(cx[i]) + DEG8_OFS_HIGH));
			if (i == 0)
				chk(32'(srch), 0);
		end
		chk(32'(srch), 1);
		chk(n_hist, 5);
		chk(n_store, 1);
		chkm(1);
		bus(1, IDX_CTRL, 8'h06);
		chkm(0);
		bus(1, IDX_STATUS, 8'h00);
		bus(1, IDX_CTRL, 8'h46);
		bus(1, IDX_CMD, CMD_CLEAR_MEM);
		bus(1, IDX_RATE, 8'h01);
		chkm(1);
		bus(1, 10'h205, 8'h00);
		chkm(0);
		bus(1, IDX_CTRL, 8'h08);
		@(posedge clk);
		chk(32'(wrap), 1);
		for (int i = 0; i < 9; i++)
		begin
			for (int j = 0; j < 4; j++)
				bus(1, IDX_ALM_SEC + 10'(j), al[i][j]);
			bus(1, IDX_STATUS, 8'h00);
			lmc_far_model_i.set_time(59, 5, 3, 2);
			k = n_alarm;
			lmc_far_model_i.tick();
			repeat (3) @(posedge clk);
			chk(n_alarm - k, 32'(al[i][4]));
			bus(0, IDX_STATUS, 8'h00);
			chk(32'(rd[ST_TAF]), 32'(al[i][4]));
		end
		test_done();
	end
endmodule
